// *** hw/sofs_status_select.v ***
`timescale 1ns/1ps
`include "sofs_defs.vh"

module sofs_status_select #(
    parameter N_OUT = 4,
    parameter TOL_W = 16
) (
    input  wire               core_clk,
    input  wire               rst_n,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    output wire [31:0]        prdata,
    output wire               pready,
    output wire               pslverr,
    input  wire               dynBrakeOn,
    input  wire               foldbackActive,
    input  wire               voltsPerHertzControl,
    input  wire               faultPresent,
    input  wire               alarmPresent,
    input  wire               cmdForward,
    input  wire               cmdReverse,
    input  wire               motorForward,
    input  wire               motorReverse,
    input  wire [TOL_W-1:0]   processErrorMag,
    input  wire [TOL_W-1:0]   positionErrorMag,
    input  wire [TOL_W-1:0]   motorSpeedMag,
    input  wire [N_OUT-1:0]   plcOut,
    input  wire [N_OUT-1:0]   rtcOut,
    input  wire               busUp,
    input  wire               heaterActive,
    input  wire               runRequest,
    output wire               driveEnable,
    output reg  [N_OUT-1:0]   statusOut
);
    wire [`SOFS_SEL_LANE*N_OUT-1:0] funcSel;
    wire [TOL_W-1:0]                posTol;
    wire [TOL_W-1:0]                spdThr;
    wire [TOL_W-1:0]                procTol;
    wire [N_OUT-1:0]                netCmd;
    wire [TOL_W-1:0]                ctcDelay;
    wire                            contactorOn;

    sofs_apb_regs #(
        .N_OUT (N_OUT),
        .TOL_W (TOL_W)
    ) u_regs (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .statusOut (statusOut),
        .funcSel   (funcSel),
        .posTol    (posTol),
        .spdThr    (spdThr),
        .procTol   (procTol),
        .netCmd    (netCmd),
        .ctcDelay  (ctcDelay)
    );

    sofs_contactor_seq #(
        .DLY_W (TOL_W)
    ) u_ctc (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .runRequest  (runRequest),
        .delayCycles (ctcDelay),
        .contactorOn (contactorOn),
        .driveEnable (driveEnable)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shared condition terms
    wire atPosition = (positionErrorMag <= posTol) && (motorSpeedMag <= spdThr);
    wire inMotion   = (positionErrorMag > posTol) || (motorSpeedMag > spdThr);
    wire procErr    = processErrorMag > procTol;

    function condition;
        input [7:0] code;
        input       netBit;
        input       plcBit;
        input       rtcBit;
        begin
            case (code[4:0] & {5{code[7:5] == 3'b000}})
                `SOFS_FN_DYN_BRAKE: condition = dynBrakeOn;
                `SOFS_FN_FOLDBACK:  condition = foldbackActive & voltsPerHertzControl;
                `SOFS_FN_FAULT:     condition = faultPresent;
                `SOFS_FN_ALARM:     condition = alarmPresent;
                `SOFS_FN_CMD_FWD:   condition = cmdForward;
                `SOFS_FN_CMD_REV:   condition = cmdReverse;
                `SOFS_FN_MOT_FWD:   condition = motorForward;
                `SOFS_FN_MOT_REV:   condition = motorReverse;
                `SOFS_FN_PROC_ERR:  condition = procErr;
                `SOFS_FN_NETWORK:   condition = netBit;
                `SOFS_FN_AT_POS:    condition = atPosition;
                `SOFS_FN_IN_MOTION: condition = inMotion;
                `SOFS_FN_PLC:       condition = plcBit;
                `SOFS_FN_RTC:       condition = rtcBit;
                `SOFS_FN_POWERED:   condition = busUp & ~faultPresent;
                `SOFS_FN_HEATER:    condition = heaterActive;
                `SOFS_FN_CONTACTOR: condition = contactorOn;
                default:            condition = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // per-output selection, registered in one process so the vector has one driver
    wire [N_OUT-1:0] next_statusOut;

    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi = gi + 1) begin : g_out
            wire [7:0] code = funcSel[gi*`SOFS_SEL_LANE +: `SOFS_SEL_LANE];
            assign next_statusOut[gi] = condition(code, netCmd[gi], plcOut[gi], rtcOut[gi]);
        end
    endgenerate

    always @(posedge core_clk) begin
        if (!rst_n)
            statusOut <= {N_OUT{1'b0}};
        else
            statusOut <= next_statusOut;
    end
endmodule

// *** include/sofs_defs.vh ***
`ifndef SOFS_DEFS_VH
`define SOFS_DEFS_VH

// function codes
`define SOFS_FN_DYN_BRAKE   5'h0f
`define SOFS_FN_FOLDBACK    5'h10
`define SOFS_FN_FAULT       5'h11
`define SOFS_FN_ALARM       5'h12
`define SOFS_FN_CMD_FWD     5'h13
`define SOFS_FN_CMD_REV     5'h14
`define SOFS_FN_MOT_FWD     5'h15
`define SOFS_FN_MOT_REV     5'h16
`define SOFS_FN_PROC_ERR    5'h17
`define SOFS_FN_NETWORK     5'h18
`define SOFS_FN_AT_POS      5'h19
`define SOFS_FN_IN_MOTION   5'h1a
`define SOFS_FN_PLC         5'h1b
`define SOFS_FN_RTC         5'h1c
`define SOFS_FN_POWERED     5'h1d
`define SOFS_FN_HEATER      5'h1e
`define SOFS_FN_CONTACTOR   5'h1f

// apb register map, byte addresses
`define SOFS_ADDR_SEL       12'h000
`define SOFS_ADDR_POS_TOL   12'h004
`define SOFS_ADDR_SPD_THR   12'h008
`define SOFS_ADDR_PROC_TOL  12'h00c
`define SOFS_ADDR_NET_CMD   12'h010
`define SOFS_ADDR_CTC_DLY   12'h014
`define SOFS_ADDR_STATUS    12'h018

// reset values
`define SOFS_RST_SEL        32'h0000_0000
`define SOFS_RST_TOL        16'h0000
`define SOFS_RST_DLY        16'h0000
`define SOFS_RST_NET        4'h0

// field layout of the select register: one 8-bit lane per output
`define SOFS_SEL_LANE       8

`endif

// *** hw/sofs_contactor_seq.v ***
`timescale 1ns/1ps
`include "sofs_defs.vh"

// contactor sequencing: close before drive enable, open after drive disable
module sofs_contactor_seq #(
    parameter DLY_W = 16
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire             runRequest,
    input  wire [DLY_W-1:0] delayCycles,
    output reg              contactorOn,
    output reg              driveEnable
);
    localparam ST_OPEN    = 2'd0;
    localparam ST_CLOSING = 2'd1;
    localparam ST_RUN     = 2'd2;
    localparam ST_OPENING = 2'd3;

    reg [1:0]       state;
    reg [DLY_W-1:0] count;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            state       <= ST_OPEN;
            count       <= `SOFS_RST_DLY;
            contactorOn <= 1'b0;
            driveEnable <= 1'b0;
        end else begin
            case (state)
                ST_OPEN: begin
                    if (runRequest) begin
                        contactorOn <= 1'b1;
                        count       <= delayCycles;
                        state       <= ST_CLOSING;
                    end
                end
                ST_CLOSING: begin
                    if (!runRequest) begin
                        contactorOn <= 1'b0;
                        state       <= ST_OPEN;
                    end else if (count == {DLY_W{1'b0}}) begin
                        driveEnable <= 1'b1;
                        state       <= ST_RUN;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!runRequest) begin
                        driveEnable <= 1'b0;
                        count       <= delayCycles;
                        state       <= ST_OPENING;
                    end
                end
                default: begin
                    if (count == {DLY_W{1'b0}}) begin
                        contactorOn <= 1'b0;
                        state       <= ST_OPEN;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

// *** hw/sofs_apb_regs.v ***
`timescale 1ns/1ps
`include "sofs_defs.vh"

// apb slave holding the configuration; zero wait states
module sofs_apb_regs #(
    parameter N_OUT = 4,
    parameter TOL_W = 16
) (
    input  wire                          core_clk,
    input  wire                          rst_n,
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [11:0]                   paddr,
    input  wire [31:0]                   pwdata,
    output reg  [31:0]                   prdata,
    output wire                          pready,
    output wire                          pslverr,
    input  wire [N_OUT-1:0]              statusOut,
    output reg  [`SOFS_SEL_LANE*N_OUT-1:0] funcSel,
    output reg  [TOL_W-1:0]              posTol,
    output reg  [TOL_W-1:0]              spdThr,
    output reg  [TOL_W-1:0]              procTol,
    output reg  [N_OUT-1:0]              netCmd,
    output reg  [TOL_W-1:0]              ctcDelay
);
    wire access = psel & penable;
    wire wrEn   = access & pwrite;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `SOFS_ADDR_SEL) || (a == `SOFS_ADDR_POS_TOL) ||
                     (a == `SOFS_ADDR_SPD_THR) || (a == `SOFS_ADDR_PROC_TOL) ||
                     (a == `SOFS_ADDR_NET_CMD) || (a == `SOFS_ADDR_CTC_DLY) ||
                     (a == `SOFS_ADDR_STATUS);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped(paddr);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            funcSel  <= `SOFS_RST_SEL;
            posTol   <= `SOFS_RST_TOL;
            spdThr   <= `SOFS_RST_TOL;
            procTol  <= `SOFS_RST_TOL;
            netCmd   <= {N_OUT{1'b0}};
            ctcDelay <= `SOFS_RST_DLY;
        end else if (wrEn) begin
            if (paddr == `SOFS_ADDR_SEL)
                funcSel <= pwdata[`SOFS_SEL_LANE*N_OUT-1:0];
            else if (paddr == `SOFS_ADDR_POS_TOL)
                posTol <= pwdata[TOL_W-1:0];
            else if (paddr == `SOFS_ADDR_SPD_THR)
                spdThr <= pwdata[TOL_W-1:0];
            else if (paddr == `SOFS_ADDR_PROC_TOL)
                procTol <= pwdata[TOL_W-1:0];
            else if (paddr == `SOFS_ADDR_NET_CMD)
                netCmd <= pwdata[N_OUT-1:0];
            else if (paddr == `SOFS_ADDR_CTC_DLY)
                ctcDelay <= pwdata[TOL_W-1:0];
        end
    end

    always @(*) begin
        prdata = 32'h0000_0000;
        if (paddr == `SOFS_ADDR_SEL)
            prdata[`SOFS_SEL_LANE*N_OUT-1:0] = funcSel;
        else if (paddr == `SOFS_ADDR_POS_TOL)
            prdata[TOL_W-1:0] = posTol;
        else if (paddr == `SOFS_ADDR_SPD_THR)
            prdata[TOL_W-1:0] = spdThr;
        else if (paddr == `SOFS_ADDR_PROC_TOL)
            prdata[TOL_W-1:0] = procTol;
        else if (paddr == `SOFS_ADDR_NET_CMD)
            prdata[N_OUT-1:0] = netCmd;
        else if (paddr == `SOFS_ADDR_CTC_DLY)
            prdata[TOL_W-1:0] = ctcDelay;
        else if (paddr == `SOFS_ADDR_STATUS)
            prdata[N_OUT-1:0] = statusOut;
    end
endmodule

// *** verification/sofs_status_monitor.sv ***
`timescale 1ns/1ps
`include "sofs_defs.vh"
module sofs_status_monitor #(
    parameter N_OUT = 4
) (
    input wire             core_clk,
    input wire             rst_n,
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire [11:0]      paddr,
    input wire [31:0]      pwdata,
    input wire             pready,
    input wire             dynBrakeOn,
    input wire             foldbackActive,
    input wire             voltsPerHertzControl,
    input wire             faultPresent,
    input wire             alarmPresent,
    input wire             cmdForward,
    input wire             busUp,
    input wire             driveEnable,
    input wire [N_OUT-1:0] statusOut
);
    logic [7:0] shadow;
    logic [7:0] codeSeen;
    // lane 0 code as the output logic used it at the previous edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shadow   <= 8'h00;
            codeSeen <= 8'h00;
        end else begin
            if (psel && penable && pwrite && pready && paddr == `SOFS_ADDR_SEL)
                shadow <= pwdata[7:0];
            codeSeen <= shadow;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_brake_follows: assert property (codeSeen == 8'h0f |->
        statusOut[0] == $past(dynBrakeOn)) else $error("brake output wrong");
    a_fold_gated: assert property (codeSeen == 8'h10 |->
        statusOut[0] == ($past(foldbackActive) && $past(voltsPerHertzControl)))
        else $error("foldback output wrong");
    a_fault_shown: assert property (codeSeen == 8'h11 |->
        statusOut[0] == $past(faultPresent)) else $error("fault output wrong");
    a_alarm_shown: assert property (codeSeen == 8'h12 |->
        statusOut[0] == $past(alarmPresent)) else $error("alarm output wrong");
    a_cmd_forward: assert property (codeSeen == 8'h13 |->
        statusOut[0] == $past(cmdForward)) else $error("command output wrong");
    a_powered_up: assert property (codeSeen == 8'h1d |->
        statusOut[0] == ($past(busUp) && !$past(faultPresent)))
        else $error("powered output wrong");
    a_unknown_off: assert property ((codeSeen < 8'h0f || codeSeen > 8'h1f) |->
        !statusOut[0]) else $error("unused code drives output");
    a_reset_clears: assert property (disable iff (1'b0) !rst_n |=>
        statusOut == '0 && !driveEnable) else $error("outputs not cleared");
    a_contactor_first: assert property (codeSeen == 8'h1f &&
        $changed(driveEnable) |-> statusOut[0]) else $error("drive moved while open");
endmodule

// *** verification/sofs_reader.sv ***
`timescale 1ns/1ps
// external equipment latching the status lines it reads
module sofs_reader (
    input  wire        core_clk,
    input  wire [3:0]  statusOut,
    output logic [3:0] seen
);
    always @(posedge core_clk) begin
        seen <= statusOut;
    end
endmodule

// *** verification/sofs_status_select_test.sv ***
`timescale 1ns/1ps
`include "sofs_defs.vh"
module sofs_status_select_test;
    logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        runRequest = 0, pready, pslverr, driveEnable, slv;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv, sel, lfsr = 32'h0000_0f0d;
    logic [10:0] cond = 0;
    logic [15:0] procErr = 0, posErr = 0, speed = 0, posTol, spdThr, procTol;
    logic [3:0]  plcOut = 0, rtcOut = 0, netCmd, statusOut, seen, expV;
    int          errTotal = 0, testsRun = 0, cyc = 0, gap;
    always #20 core_clk = ~core_clk;
    sofs_status_select #(.N_OUT(4), .TOL_W(16)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dynBrakeOn(cond[0]),
        .foldbackActive(cond[1]), .voltsPerHertzControl(cond[2]), .faultPresent(cond[3]),
        .alarmPresent(cond[4]), .cmdForward(cond[5]), .cmdReverse(cond[6]),
        .motorForward(cond[7]), .motorReverse(cond[8]), .processErrorMag(procErr),
        .positionErrorMag(posErr), .motorSpeedMag(speed), .plcOut(plcOut), .rtcOut(rtcOut),
        .busUp(cond[9]), .heaterActive(cond[10]), .runRequest(runRequest),
        .driveEnable(driveEnable), .statusOut(statusOut));
    sofs_reader far (.core_clk(core_clk), .statusOut(statusOut), .seen(seen));
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] nextRand(input logic [31:0] v);
        return v[0] ? (v >> 1) ^ 32'h8020_0003 : v >> 1;
    endfunction
    function logic expBit(input logic [7:0] c, input int i);
        case (c)
            `SOFS_FN_DYN_BRAKE: return cond[0];
            `SOFS_FN_FOLDBACK: return cond[1] & cond[2];
            `SOFS_FN_FAULT: return cond[3];
            `SOFS_FN_ALARM: return cond[4];
            `SOFS_FN_CMD_FWD: return cond[5];
            `SOFS_FN_CMD_REV: return cond[6];
            `SOFS_FN_MOT_FWD: return cond[7];
            `SOFS_FN_MOT_REV: return cond[8];
            `SOFS_FN_PROC_ERR: return procErr > procTol;
            `SOFS_FN_NETWORK: return netCmd[i];
            `SOFS_FN_AT_POS: return posErr <= posTol && speed <= spdThr;
            `SOFS_FN_IN_MOTION: return posErr > posTol || speed > spdThr;
            `SOFS_FN_PLC: return plcOut[i];
            `SOFS_FN_RTC: return rtcOut[i];
            `SOFS_FN_POWERED: return cond[9] & ~cond[3];
            `SOFS_FN_HEATER: return cond[10];
            default: return 1'b0;
        endcase
    endfunction
    task closeOut;
        if (errTotal == 0 && testsRun > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task checkVal(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // called right after a rising edge; returns right after the edge that follows release
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // time from status line change to drive enable change, same direction
    task measure(input logic lvl, output int g);
        int ts, td;
        ts = -1;
        td = -1;
        for (int k = 0; k < 20; k++) begin
            @(posedge core_clk);
            #1;
            if (ts < 0 && statusOut[0] === lvl) ts = k;
            if (td < 0 && driveEnable === lvl) td = k;
        end
        g = td - ts;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            closeOut();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            apb(1'b0, 12'(a), 32'h0000_0000);
            checkVal(rdv, 32'h0000_0000);
        end
        apb(1'b1, 12'h020, 32'hffff_ffff);
        apb(1'b0, 12'h020, 32'h0000_0000);
        checkVal({rdv[30:0], slv}, 32'h0000_0001);
        for (int n = 0; n < 150; n++) begin
            for (int i = 0; i < 4; i++) begin
                lfsr = nextRand(lfsr);
                sel[8*i+:8] = (n % 8 == 0) ? lfsr[7:0] : 8'h0f + lfsr[7:0] % 8'h11;
            end
            lfsr = nextRand(lfsr);
            posTol = lfsr[3:0];
            spdThr = lfsr[7:4];
            procTol = lfsr[11:8];
            netCmd = lfsr[15:12];
            apb(1'b1, `SOFS_ADDR_SEL, sel);
            apb(1'b1, `SOFS_ADDR_POS_TOL, {16'h0000, posTol});
            apb(1'b1, `SOFS_ADDR_SPD_THR, {16'h0000, spdThr});
            apb(1'b1, `SOFS_ADDR_PROC_TOL, {16'h0000, procTol});
            apb(1'b1, `SOFS_ADDR_NET_CMD, {28'h000_0000, netCmd});
            lfsr = nextRand(lfsr);
            cond <= lfsr[10:0];
            plcOut <= lfsr[14:11];
            rtcOut <= lfsr[18:15];
            procErr <= lfsr[23:19];
            posErr <= lfsr[28:24];
            speed <= lfsr[31:27];
            @(posedge core_clk);
            #1;
            for (int i = 0; i < 4; i++) expV[i] = expBit(sel[8*i+:8], i);
            checkVal({28'h000_0000, statusOut}, {28'h000_0000, expV});
            @(posedge core_clk);
            apb(1'b0, `SOFS_ADDR_STATUS, 32'h0000_0000);
            checkVal(rdv, {28'h000_0000, expV});
            checkVal({28'h000_0000, seen}, {28'h000_0000, expV});
            apb(1'b0, `SOFS_ADDR_SEL, 32'h0000_0000);
            checkVal(rdv, sel);
            // mid-run reset while outputs are live
            if (n == 75) begin
                rst_n <= 1'b0;
                repeat (2) @(posedge core_clk);
                rst_n <= 1'b1;
                #1;
                checkVal({28'h000_0000, statusOut}, 32'h0000_0000);
                @(posedge core_clk);
            end
        end
        apb(1'b1, `SOFS_ADDR_CTC_DLY, 32'h0000_0003);
        apb(1'b1, `SOFS_ADDR_SEL, 32'h0000_001f);
        runRequest <= 1'b1;
        measure(1'b1, gap);
        checkVal(gap, 32'h0000_0003);
        @(posedge core_clk);
        runRequest <= 1'b0;
        measure(1'b0, gap);
        checkVal(gap, 32'hffff_fffb);
        closeOut();
    end
endmodule
bind sofs_status_select sofs_status_monitor #(.N_OUT(N_OUT)) mon (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .dynBrakeOn(dynBrakeOn),
    .foldbackActive(foldbackActive), .voltsPerHertzControl(voltsPerHertzControl),
    .faultPresent(faultPresent), .alarmPresent(alarmPresent), .cmdForward(cmdForward),
    .busUp(busUp), .driveEnable(driveEnable), .statusOut(statusOut));
